/* src/byte_op_execute_subset.sv */
// Execute datapath for a subset of byte and literal operations.
// Assumes the file bank is outside: file data arrives combinationally for fileAddr,
// and a file write is requested through fileWe/fileWaddr/fileWdata one cycle later.
`timescale 1ns/1ps
`default_nettype none
module byte_op_execute_subset
	import byte_op_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic                       ce,
	input  wire logic                       opValid,
	input  wire byte_op_pkg::op_t           op,
	input  wire logic [byte_op_pkg::ADDR_W-1:0] fileAddr,
	input  wire logic                       dest,
	input  wire logic [byte_op_pkg::DATA_W-1:0] literal,
	input  wire logic [byte_op_pkg::DATA_W-1:0] fileRdata,
	output logic [byte_op_pkg::DATA_W-1:0]  acc,
	output logic                            nullFlag,
	output logic                            fileWe,
	output logic [byte_op_pkg::ADDR_W-1:0]  fileWaddr,
	output logic [byte_op_pkg::DATA_W-1:0]  fileWdata,
	output logic                            skipNext,
	output logic                            idleOp
);
	logic rstMeta;
	logic rstSync;
	logic [DATA_W-1:0] result;
	logic useDest;
	logic setsNull;
	logic isSkipOp;
	logic doOp;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// An idle slot executes nothing, which is how the skip takes effect
	assign doOp = ce && opValid && !skipNext;

	always_comb begin
		result = ACC_RESET;
		useDest = 1'b0;
		setsNull = 1'b0;
		isSkipOp = 1'b0;
		unique case (op)
			// [RQ1] decrement to dest
			OP_DEC_SKIP: begin
				result = fileRdata - ONE;
				useDest = 1'b1;
				isSkipOp = 1'b1;
			end
			// [RQ3] increment, no flags
			OP_INC_SKIP: begin
				result = fileRdata + ONE;
				useDest = 1'b1;
				isSkipOp = 1'b1;
			end
			// [RQ6] OR literal
			OP_OR_LIT: begin
				result = acc | literal;
				setsNull = 1'b1;
			end
			// [RQ7] OR file to dest
			OP_OR_FILE: begin
				result = acc | fileRdata;
				useDest = 1'b1;
				setsNull = 1'b1;
			end
			// [RQ8] literal as given
			OP_LOAD_LIT: result = literal;
			// [RQ9] accumulator to file
			OP_STORE_ACC: result = acc;
			OP_NONE: result = ACC_RESET;
			// Spare code 7 executes as nothing
			default: result = ACC_RESET;
		endcase
	end

	// Accumulator update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc <= ACC_RESET;
		end else if (!rstSync) begin
			acc <= ACC_RESET;
		end else if (doOp) begin
			if ((useDest && dest == DEST_ACC) || op == OP_OR_LIT || op == OP_LOAD_LIT) begin
				acc <= result;
			end
		end
	end

	// File write request; [RQ5] 7-bit address and one destination bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fileWe <= 1'b0;
			fileWaddr <= '0;
			fileWdata <= ACC_RESET;
		end else if (!rstSync) begin
			fileWe <= 1'b0;
		end else if (ce) begin
			fileWe <= doOp && ((useDest && dest == DEST_FILE) || op == OP_STORE_ACC);
			fileWaddr <= fileAddr;
			fileWdata <= result;
		end
	end

	// [RQ10] null flag from result
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nullFlag <= 1'b0;
		end else if (!rstSync) begin
			nullFlag <= 1'b0;
		end else if (doOp && setsNull) begin
			nullFlag <= (result == ACC_RESET);
		end
	end

	// [RQ2] [RQ4] zero result idles next
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			skipNext <= 1'b0;
			idleOp <= 1'b0;
		end else if (!rstSync) begin
			skipNext <= 1'b0;
			idleOp <= 1'b0;
		end else if (ce) begin
			skipNext <= doOp && isSkipOp && (result == ACC_RESET);
			idleOp <= skipNext && opValid;
		end
	end

	// [RQ2] zero decrement skips
	AST_DEC_SKIP: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_DEC_SKIP && fileRdata == ONE) |=> skipNext)
		else $error("decrement to zero did not skip");
	// [RQ4] zero increment skips
	AST_INC_SKIP: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_INC_SKIP && fileRdata == 8'hff) |=> skipNext)
		else $error("increment to zero did not skip");
	// [RQ2] nonzero no skip
	AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rstSync)
		(ce && !(doOp && isSkipOp && result == ACC_RESET)) |=> !skipNext)
		else $error("skip without zero result");
	// [RQ1] decrement to file
	AST_DEC_FILE: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_DEC_SKIP && dest == DEST_FILE) |=>
		(fileWe && fileWdata == $past(fileRdata) - ONE && acc == $past(acc)))
		else $error("decrement to file wrong");
	// [RQ3] increment keeps flag
	AST_INC_FLAG: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_INC_SKIP && dest == DEST_ACC) |=>
		(acc == $past(fileRdata) + ONE && $stable(nullFlag)))
		else $error("increment wrong or flag touched");
	// [RQ6] OR literal
	AST_OR_LIT: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_OR_LIT) |=> (acc == ($past(acc) | $past(literal))))
		else $error("or literal result wrong");
	// [RQ7] OR file to file
	AST_OR_FILE: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_OR_FILE && dest == DEST_FILE) |=>
		(fileWe && fileWdata == ($past(acc) | $past(fileRdata))))
		else $error("or file result wrong");
	// [RQ8] load literal
	AST_LOAD: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_LOAD_LIT) |=> (acc == $past(literal) && $stable(nullFlag)))
		else $error("load literal wrong");
	// [RQ9] store accumulator
	AST_STORE: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_STORE_ACC) |=>
		(fileWe && fileWdata == $past(acc) && fileWaddr == $past(fileAddr) && $stable(nullFlag)))
		else $error("store accumulator wrong");
	// [RQ10] null flag value
	AST_NULL: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && setsNull) |=>
		(nullFlag == (fileWe ? (fileWdata == ACC_RESET) : (acc == ACC_RESET))))
		else $error("null flag wrong");
	// [RQ5] write address follows
	AST_ADDR: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && useDest && dest == DEST_FILE) |=> (fileWaddr == $past(fileAddr)))
		else $error("file address lost");
	// Clock enable low holds acc, nullFlag, fileWe, fileWdata, skipNext and idleOp
	AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!rstSync)
		!ce |=> ($stable(acc) && $stable(nullFlag) && $stable(fileWe) && $stable(skipNext)
		&& $stable(idleOp) && $stable(fileWdata)))
		else $error("state moved while clock enable low");
	// [RQ2] skipped op discarded
	AST_SKIP_DISCARD: assert property (@(posedge clk) disable iff (!rstSync)
		(ce && skipNext) |=>
		(acc == $past(acc) && !fileWe && $stable(nullFlag) && !skipNext))
		else $error("skipped operation took effect");
	// [RQ4] discarded op reported
	AST_IDLE: assert property (@(posedge clk) disable iff (!rstSync)
		(ce && skipNext && opValid) |=> idleOp)
		else $error("idle slot not reported");
	// [RQ2] no idle without skip
	AST_NO_IDLE: assert property (@(posedge clk) disable iff (!rstSync)
		(ce && !skipNext) |=> !idleOp)
		else $error("idle reported without skip");
	// [RQ1] decrement to accumulator
	AST_DEC_ACC: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_DEC_SKIP && dest == DEST_ACC) |=>
		(acc == $past(fileRdata) - ONE && !fileWe && $stable(nullFlag)))
		else $error("decrement to accumulator wrong");
	// [RQ3] increment to file
	AST_INC_FILE: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_INC_SKIP && dest == DEST_FILE) |=>
		(fileWe && fileWdata == $past(fileRdata) + ONE && acc == $past(acc) && $stable(nullFlag)))
		else $error("increment to file wrong");
	// [RQ7] OR file to accumulator
	AST_OR_ACC: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_OR_FILE && dest == DEST_ACC) |=>
		(acc == ($past(acc) | $past(fileRdata)) && !fileWe))
		else $error("or file to accumulator wrong");
	// [RQ4] nonzero increment runs next
	AST_INC_NOSKIP: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_INC_SKIP && fileRdata != 8'hff) |=> !skipNext)
		else $error("nonzero increment skipped");
	// [RQ2] nonzero decrement runs next
	AST_DEC_NOSKIP: assert property (@(posedge clk) disable iff (!rstSync)
		(doOp && op == OP_DEC_SKIP && fileRdata != ONE) |=> !skipNext)
		else $error("nonzero decrement skipped");
	// [RQ10] flag only moves on update
	AST_NULL_HOLD: assert property (@(posedge clk) disable iff (!rstSync)
		(ce && !(doOp && setsNull)) |=> $stable(nullFlag))
		else $error("null flag changed without update");
endmodule
`default_nettype wire

/* src/byte_op_pkg.sv */
// Constants and types for the byte-operation execute datapath.
// Assumes the instruction decoder presents one operation per instruction cycle.
// Operation
// [RQ1] Decrement-and-skip writes file minus one to the accumulator when the destination bit is 0, else to the file.
// [RQ2] A zero decrement result turns the next instruction into an idle operation.
// [RQ3] Increment-and-skip writes file plus one per the destination bit and leaves the flags alone.
// [RQ4] A zero increment result turns the next instruction into an idle operation.
// [RQ5] Byte operations take a 7-bit file address (0 to 127) and a one-bit destination select.
// [RQ6] OR-with-literal ORs the accumulator with an 8-bit literal into the accumulator and updates the null flag.
// [RQ7] OR-with-file ORs accumulator and file into the selected destination and updates the null flag.
// [RQ8] Load-literal places the literal in the accumulator with no flag change.
// [RQ9] Store-accumulator copies the accumulator into the addressed file with no flag change.
// [RQ10] The null flag is set when the updating result is zero and cleared otherwise.
package byte_op_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ONE = 8'h01;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_DEC_SKIP,
		OP_INC_SKIP,
		OP_OR_LIT,
		OP_OR_FILE,
		OP_LOAD_LIT,
		OP_STORE_ACC
	} op_t;
endpackage

/* verif/testbench.sv */
// Self-checking bench for the byte-operation execute datapath.
// Assumes the design sources are compiled first; the bench stands in for the file bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
	import byte_op_pkg::*;
	logic              clk, arst_n, ce, opValid, dest, nullFlag, fileWe, skipNext, idleOp;
	op_t               op;
	logic [ADDR_W-1:0] fileAddr, fileWaddr;
	logic [DATA_W-1:0] literal, fileRdata, acc, fileWdata;
	int                errors, n_compared;

	byte_op_execute_subset byte_op_execute_subset_inst (.clk(clk), .arst_n(arst_n), .ce(ce),
		.opValid(opValid), .op(op), .fileAddr(fileAddr), .dest(dest), .literal(literal),
		.fileRdata(fileRdata), .acc(acc), .nullFlag(nullFlag), .fileWe(fileWe),
		.fileWaddr(fileWaddr), .fileWdata(fileWdata), .skipNext(skipNext), .idleOp(idleOp));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Presents one operation and returns once its edge has landed
	task automatic go(op_t o, logic [6:0] a, logic d, logic [7:0] k, logic [7:0] f);
		opValid = 1'b1; op = o; fileAddr = a; dest = d; literal = k; fileRdata = f;
		@(posedge clk);
		#2;
	endtask

	task automatic idle;
		opValid = 1'b0;
		@(posedge clk);
		#2;
	endtask

	task automatic t_literal;
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h5a, 8'h00);
		`CHK("acc", 8'h5a, acc)
		go(OP_OR_LIT, 7'h00, 1'b0, 8'ha1, 8'h00);
		`CHK("acc", 8'hfb, acc)
		`CHK("null", 1'b0, nullFlag)
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h00, 8'h00);
		go(OP_OR_LIT, 7'h00, 1'b0, 8'h00, 8'h00);
		`CHK("null", 1'b1, nullFlag)
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h11, 8'h00);
		`CHK("null", 1'b1, nullFlag)
	endtask

	task automatic t_file;
		go(OP_STORE_ACC, 7'h7f, 1'b0, 8'h00, 8'h00);
		`CHK("we", 1'b1, fileWe)
		`CHK("waddr", 7'h7f, fileWaddr)
		`CHK("wdata", 8'h11, fileWdata)
		`CHK("null", 1'b1, nullFlag)
		go(OP_OR_FILE, 7'h05, 1'b1, 8'h00, 8'h22);
		`CHK("wdata", 8'h33, fileWdata)
		`CHK("acc", 8'h11, acc)
		`CHK("null", 1'b0, nullFlag)
		go(OP_OR_FILE, 7'h05, 1'b0, 8'h00, 8'h44);
		`CHK("acc", 8'h55, acc)
		`CHK("we", 1'b0, fileWe)
	endtask

	task automatic t_dec;
		go(OP_DEC_SKIP, 7'h00, 1'b0, 8'h00, 8'h01);
		`CHK("acc", 8'h00, acc)
		`CHK("we", 1'b0, fileWe)
		`CHK("skip", 1'b1, skipNext)
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'hff, 8'h00);
		`CHK("acc", 8'h00, acc)
		`CHK("idle", 1'b1, idleOp)
		go(OP_DEC_SKIP, 7'h40, 1'b1, 8'h00, 8'h05);
		`CHK("wdata", 8'h04, fileWdata)
		`CHK("skip", 1'b0, skipNext)
	endtask

	task automatic t_inc;
		go(OP_INC_SKIP, 7'h01, 1'b1, 8'h00, 8'hff);
		`CHK("wdata", 8'h00, fileWdata)
		`CHK("skip", 1'b1, skipNext)
		go(OP_INC_SKIP, 7'h01, 1'b0, 8'h00, 8'h07);
		`CHK("acc", 8'h00, acc)
		go(OP_INC_SKIP, 7'h01, 1'b0, 8'h00, 8'h07);
		`CHK("acc", 8'h08, acc)
		`CHK("skip", 1'b0, skipNext)
		`CHK("null", 1'b0, nullFlag)
	endtask

	// A pending skip survives a frozen cycle and hits the next executed slot
	task automatic t_freeze;
		go(OP_INC_SKIP, 7'h02, 1'b0, 8'h00, 8'hff);
		`CHK("acc", 8'h00, acc)
		`CHK("skip", 1'b1, skipNext)
		ce = 1'b0;
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h55, 8'h00);
		`CHK("skip", 1'b1, skipNext)
		`CHK("acc", 8'h00, acc)
		ce = 1'b1;
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h66, 8'h00);
		`CHK("acc", 8'h00, acc)
		`CHK("idle", 1'b1, idleOp)
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h66, 8'h00);
		`CHK("acc", 8'h66, acc)
	endtask

	// Reset in mid-run drops a pending skip; first op lands at the third edge
	task automatic t_reset;
		go(OP_INC_SKIP, 7'h03, 1'b0, 8'h00, 8'hff);
		`CHK("skip", 1'b1, skipNext)
		arst_n = 1'b0;
		idle();
		`CHK("skip", 1'b0, skipNext)
		arst_n = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		go(OP_LOAD_LIT, 7'h00, 1'b0, 8'h3c, 8'h00);
		`CHK("acc", 8'h3c, acc)
	endtask

	task automatic give_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#40000;
		errors++;
		give_verdict();
	end

	initial begin
		arst_n = 1'b0; ce = 1'b1; opValid = 1'b0; op = OP_NONE; fileAddr = 7'h00;
		dest = 1'b0; literal = 8'h00; fileRdata = 8'h00; errors = 0; n_compared = 0;
		repeat (12) @(posedge clk);
		#2 arst_n = 1'b1;
		// Internal reset copy lags by two flops
		repeat (4) @(posedge clk);
		#2;
		t_literal();
		t_file();
		t_dec();
		t_inc();
		t_freeze();
		t_reset();
		idle();
		give_verdict();
	end
endmodule
`default_nettype wire
